// ==== rtl/pmr_pkg.sv ====
// Package for the power management and reset controller: offsets of the
// configuration registers, field positions, reset values and cycle counts.
// Assumes a single 250 MHz system clock feeding every module.
`default_nettype none
package pmr_pkg;
   // System clock period and reset pulse limits in their own units
   localparam int CLK_PERIOD_NS        = 4;
   localparam int RESET_PULSE_MIN_NS   = 700000;
   localparam int RESET_PULSE_MAX_NS   = 2000000;
   // Least time rounds up, longest rounds down
   localparam int RESET_PULSE_CYCLES   = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_PULSE_MAX_CYC  = RESET_PULSE_MAX_NS / CLK_PERIOD_NS;
   localparam int RST_CNT_W            = 19;

   // Configuration register indices on the write port
   localparam logic [1:0] CFG_IDX_LEVEL     = 2'h0;
   localparam logic [1:0] CFG_IDX_MODE      = 2'h1;
   localparam logic [1:0] CFG_IDX_RATE_LOW  = 2'h2;
   localparam logic [1:0] CFG_IDX_RATE_HIGH = 2'h3;

   // Field positions
   localparam int LVL_SEL_LSB         = 0;
   localparam int MODE_RX_POLICY_BIT  = 0;
   localparam int MODE_BYPASS_BIT     = 1;
   localparam int RATE_FRAC_EN_BIT    = 7;
   localparam int RATE_WORD_W         = 15;

   // Values after reset
   localparam logic [7:0] CFG_LEVEL_RST     = 8'h04;
   localparam logic [7:0] CFG_MODE_RST      = 8'h00;
   localparam logic [7:0] CFG_RATE_LOW_RST  = 8'h00;
   localparam logic [7:0] CFG_RATE_HIGH_RST = 8'h00;

   // Converter level coding
   localparam logic [2:0]  LVL_CODE_1V4 = 3'h3;
   localparam logic [10:0] LVL_BASE_MV  = 11'h44C;
   localparam logic [10:0] LVL_STEP_MV  = 11'h064;

   // Fixed divider length
   localparam logic [1:0] DIV4_LAST = 2'h3;

   typedef enum logic [1:0] {PMR_ST_OFF, PMR_ST_PULSE, PMR_ST_RUN} pmr_rst_state_t;

   // Level code to millivolts; code zero requests no level
   function automatic logic [10:0] pmr_level_mv(input logic [2:0] code);
      logic [10:0] mv;
      mv = (code == 3'h0) ? 11'h000 : 11'(LVL_BASE_MV + LVL_STEP_MV * 11'(code));
      return mv;
   endfunction
endpackage
`default_nettype wire

// ==== rtl/pmr_reset_gen.sv ====
// Internal reset sequencer: timed pulse after supply good or shutdown release,
// plus a one-cycle partial reset on the soft command.
// Assumes supply_ok and shutdown are already synchronised.
`default_nettype none
module pmr_reset_gen #(
   parameter int RESET_CYCLES = pmr_pkg::RESET_PULSE_CYCLES
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic supply_ok,
   input  wire logic shutdown,
   input  wire logic soft_cmd,
   output logic      reset_n_r,
   output logic      partial_n_r
);
   import pmr_pkg::*;
   localparam logic [RST_CNT_W-1:0] CNT_LAST = RST_CNT_W'(RESET_CYCLES - 1);

   pmr_rst_state_t       state_r, state_nxt;
   logic [RST_CNT_W-1:0] cnt_r,   cnt_nxt;
   logic                 reset_n_nxt, partial_n_nxt;
   logic                 off_req;

   // Sequencer next state; supply loss or shutdown always wins
   always_comb begin
      off_req       = !supply_ok || shutdown;
      state_nxt     = state_r;
      cnt_nxt       = cnt_r;
      unique case (state_r)
         PMR_ST_OFF: begin
            cnt_nxt = '0;
            if (!off_req) state_nxt = PMR_ST_PULSE;
         end
         PMR_ST_PULSE: begin
            cnt_nxt = cnt_r + 1'b1;
            if (off_req) state_nxt = PMR_ST_OFF;
            else if (cnt_r == CNT_LAST) state_nxt = PMR_ST_RUN;
         end
         PMR_ST_RUN: begin
            if (off_req) state_nxt = PMR_ST_OFF;
         end
      endcase
      // Release taken from the next state so reset_n_r and state_r change on the same edge
      reset_n_nxt   = (state_nxt == PMR_ST_RUN);
      partial_n_nxt = !(soft_cmd && state_r == PMR_ST_RUN);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r     <= PMR_ST_OFF;
         cnt_r       <= '0;
         reset_n_r   <= 1'b0;
         partial_n_r <= 1'b1;
      end else begin
         state_r     <= state_nxt;
         cnt_r       <= cnt_nxt;
         reset_n_r   <= reset_n_nxt;
         partial_n_r <= partial_n_nxt;
      end
   end

   // Release only after the full count
   pulse_len_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(reset_n_r) |-> $past(cnt_r) == CNT_LAST)
      else $error("reset released before full pulse");

   // Shutdown release starts a new pulse
   sdn_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
      (state_r == PMR_ST_OFF && supply_ok && !shutdown) |=> state_r == PMR_ST_PULSE ##1
      (!reset_n_r || $past(state_r) != PMR_ST_PULSE))
      else $error("no pulse after shutdown release");
endmodule
`default_nettype wire

// ==== rtl/pmr_sw_clk.sv ====
// Converter switching clock: fixed divide by four or fractional phase
// accumulator, both stepped by the digital-domain enable.
// Assumes dig_en is a one-cycle pulse on the system clock.
`default_nettype none
module pmr_sw_clk (
   input  wire logic                            clk,
   input  wire logic                            nrst,
   input  wire logic                            run,
   input  wire logic                            dig_en,
   input  wire logic                            frac_en,
   input  wire logic [pmr_pkg::RATE_WORD_W-1:0] rate_word,
   output logic                                 sw_clk_r
);
   import pmr_pkg::*;

   logic [1:0]             div_r,  div_nxt;
   logic [RATE_WORD_W-1:0] acc_r,  acc_nxt;
   logic                   sw_nxt;

   // Both dividers step on the digital tick; held at zero out of run
   always_comb begin
      div_nxt = div_r;
      acc_nxt = acc_r;
      if (!run) begin
         div_nxt = '0;
         acc_nxt = '0;
      end else if (dig_en) begin
         div_nxt = div_r + 1'b1;
         acc_nxt = acc_r + rate_word;
      end
      // Accumulator MSB runs at word * f_dig / 2^15
      sw_nxt = frac_en ? acc_r[RATE_WORD_W-1] : div_r[1];
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_r    <= '0;
         acc_r    <= '0;
         sw_clk_r <= 1'b0;
      end else begin
         div_r    <= div_nxt;
         acc_r    <= acc_nxt;
         sw_clk_r <= sw_nxt;
      end
   end

   // Fixed mode: high for two ticks of every four
   div4_a: assert property (@(posedge clk) disable iff (!nrst)
      (run && !frac_en && dig_en && div_r == DIV4_LAST) ##1 (run && !frac_en)
      |-> ##1 !sw_clk_r)
      else $error("divide by four phase wrong");

   // Accumulator adds the word each tick
   frac_acc_a: assert property (@(posedge clk) disable iff (!nrst)
      (run && dig_en) |=> acc_r == RATE_WORD_W'($past(acc_r) + $past(rate_word)))
      else $error("fractional step wrong");
endmodule
`default_nettype wire

// ==== rtl/pmr_power_reset_ctrl.sv ====
// Top of the power management and reset controller: configuration holding
// registers, converter level and bypass selection, switching clock, internal
// reset and I/O gating. Assumes host writes arrive on SYS_CLK; pins are async.
//
// Behaviour
// - Level codes 1..7 select 1.2 V to 1.8 V in 0.1 V steps.
// - Policy bit set forces 1.4 V in receive; clear uses programmed level.
// - Fractional enable clear: switching clock is digital clock over four.
// - Fractional enable set: rate is word times digital clock over 2^15.
// - Digital clock equals crystal, or half it for the doubled crystals.
// - Divider enable and rate word live in two host-written registers.
// - Bypass field selects isolation mode or low-power regulator bypass.
// - Internal reset pulse lasts about 0.7 to 2 ms after supply good.
// - Every configuration register returns to its default on full reset.
// - Shutdown release with good supply gives the same reset pulse.
// - Internal reset is visible on the first general pin.
// - Soft command gives a partial reset, not the full pulse.
// - Shutdown drives the I/O gating signal which disables digital I/O.
`default_nettype none
module pmr_power_reset_ctrl #(
   parameter int RESET_CYCLES = pmr_pkg::RESET_PULSE_CYCLES
) (
   input  wire logic        SYS_CLK,
   input  wire logic        NRST,
   input  wire logic        SUPPLY_OK,
   input  wire logic        SHUTDOWN_INPUT,
   input  wire logic        XO_DOUBLE,
   input  wire logic        SOFT_PARTIAL_RESET_CMD,
   input  wire logic        RX_ACTIVE,
   input  wire logic        CFG_WE,
   input  wire logic [1:0]  CFG_IDX,
   input  wire logic [7:0]  CFG_WDATA,
   output logic [7:0]       POWER_CFG_LEVEL,
   output logic [7:0]       POWER_CFG_MODE,
   output logic [7:0]       POWER_CFG_RATE_LOW,
   output logic [7:0]       POWER_CFG_RATE_HIGH,
   output logic [2:0]       CONVERTER_LEVEL_SEL,
   output logic [10:0]      CONVERTER_LEVEL_MV,
   output logic             REGULATOR_BYPASS_SEL,
   output logic             DIG_CLK_EN,
   output logic             SWITCH_CLK,
   output logic             INTERNAL_RESET_N,
   output logic             PARTIAL_RESET_N,
   output logic             FIRST_GENERAL_PIN_O,
   output logic             FIRST_GENERAL_PIN_OE,
   output logic             IO_GATING_SIGNAL
);
   import pmr_pkg::*;

   // Pin synchronisers; stage one feeds stage two only
   // Cleared to zero, so supply reads as lost until two edges have passed
   logic [2:0] sync1_r, sync1_nxt;
   logic [2:0] sync2_r, sync2_nxt;
   logic       supply_ok_s, shutdown_s, xo_double_s;

   always_comb begin
      sync1_nxt = {XO_DOUBLE, SHUTDOWN_INPUT, SUPPLY_OK};
      sync2_nxt = sync1_r;
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
      end
   end

   assign supply_ok_s = sync2_r[0];
   assign shutdown_s  = sync2_r[1];
   assign xo_double_s = sync2_r[2];

   // Internal reset sequencer
   logic int_reset_n;
   logic partial_n;

   pmr_reset_gen #(
      .RESET_CYCLES (RESET_CYCLES)
   ) u_reset_gen (
      .clk         (SYS_CLK),
      .nrst        (NRST),
      .supply_ok   (supply_ok_s),
      .shutdown    (shutdown_s),
      .soft_cmd    (SOFT_PARTIAL_RESET_CMD),
      .reset_n_r   (int_reset_n),
      .partial_n_r (partial_n)
   );

   // Digital-domain tick: every cycle, or every other with a doubled crystal
   logic dig_phase_r, dig_phase_nxt;
   logic dig_en_nxt;

   always_comb begin
      dig_phase_nxt = xo_double_s ? !dig_phase_r : 1'b0;
      dig_en_nxt    = !xo_double_s || dig_phase_r;
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         dig_phase_r <= 1'b0;
         DIG_CLK_EN  <= 1'b0;
      end else begin
         dig_phase_r <= dig_phase_nxt;
         DIG_CLK_EN  <= dig_en_nxt;
      end
   end

   // Configuration registers; writes during reset are dropped, full reset
   // reloads defaults so a shutdown cycle leaves nothing stale
   logic [7:0] lvl_nxt, mode_nxt, rlo_nxt, rhi_nxt;

   always_comb begin
      lvl_nxt  = POWER_CFG_LEVEL;
      mode_nxt = POWER_CFG_MODE;
      rlo_nxt  = POWER_CFG_RATE_LOW;
      rhi_nxt  = POWER_CFG_RATE_HIGH;
      if (!int_reset_n) begin
         lvl_nxt  = CFG_LEVEL_RST;
         mode_nxt = CFG_MODE_RST;
         rlo_nxt  = CFG_RATE_LOW_RST;
         rhi_nxt  = CFG_RATE_HIGH_RST;
      end else if (CFG_WE) begin
         unique case (CFG_IDX)
            CFG_IDX_LEVEL:     lvl_nxt  = CFG_WDATA;
            CFG_IDX_MODE:      mode_nxt = CFG_WDATA;
            CFG_IDX_RATE_LOW:  rlo_nxt  = CFG_WDATA;
            CFG_IDX_RATE_HIGH: rhi_nxt  = CFG_WDATA;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         POWER_CFG_LEVEL     <= CFG_LEVEL_RST;
         POWER_CFG_MODE      <= CFG_MODE_RST;
         POWER_CFG_RATE_LOW  <= CFG_RATE_LOW_RST;
         POWER_CFG_RATE_HIGH <= CFG_RATE_HIGH_RST;
      end else begin
         POWER_CFG_LEVEL     <= lvl_nxt;
         POWER_CFG_MODE      <= mode_nxt;
         POWER_CFG_RATE_LOW  <= rlo_nxt;
         POWER_CFG_RATE_HIGH <= rhi_nxt;
      end
   end

   // Field extraction
   logic [2:0]             converter_level_sel;
   logic                   rx_level_policy;
   logic                   regulator_bypass_sel;
   logic                   fractional_divider_en;
   logic [RATE_WORD_W-1:0] switching_rate_word;

   assign converter_level_sel   = POWER_CFG_LEVEL[LVL_SEL_LSB +: 3];
   assign rx_level_policy       = POWER_CFG_MODE[MODE_RX_POLICY_BIT];
   assign regulator_bypass_sel  = POWER_CFG_MODE[MODE_BYPASS_BIT];
   assign fractional_divider_en = POWER_CFG_RATE_HIGH[RATE_FRAC_EN_BIT];
   assign switching_rate_word   = {POWER_CFG_RATE_HIGH[6:0], POWER_CFG_RATE_LOW};

   // Effective converter level; the host keeps isolation-mode levels legal,
   // the block does not clamp them
   logic [2:0]  eff_lvl_nxt;
   logic [10:0] eff_mv_nxt;
   logic        bypass_nxt;

   always_comb begin
      eff_lvl_nxt = (rx_level_policy && RX_ACTIVE) ? LVL_CODE_1V4
                                                   : converter_level_sel;
      eff_mv_nxt  = pmr_level_mv(eff_lvl_nxt);
      bypass_nxt  = regulator_bypass_sel;
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         CONVERTER_LEVEL_SEL  <= 3'h0;
         CONVERTER_LEVEL_MV   <= 11'h000;
         REGULATOR_BYPASS_SEL <= 1'b0;
      end else begin
         CONVERTER_LEVEL_SEL  <= eff_lvl_nxt;
         CONVERTER_LEVEL_MV   <= eff_mv_nxt;
         REGULATOR_BYPASS_SEL <= bypass_nxt;
      end
   end

   // Switching clock; soft reset restarts its phase too
   logic sw_run;
   assign sw_run = int_reset_n && partial_n;

   pmr_sw_clk u_sw_clk (
      .clk       (SYS_CLK),
      .nrst      (NRST),
      .run       (sw_run),
      .dig_en    (DIG_CLK_EN),
      .frac_en   (fractional_divider_en),
      .rate_word (switching_rate_word),
      .sw_clk_r  (SWITCH_CLK)
   );

   // Reset, partial reset, pin mirror and I/O gating outputs
   logic gpio_oe_nxt;

   always_comb begin
      gpio_oe_nxt = !shutdown_s;
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         INTERNAL_RESET_N     <= 1'b0;
         PARTIAL_RESET_N      <= 1'b1;
         FIRST_GENERAL_PIN_O  <= 1'b0;
         FIRST_GENERAL_PIN_OE <= 1'b0;
         IO_GATING_SIGNAL     <= 1'b1;
      end else begin
         INTERNAL_RESET_N     <= int_reset_n;
         PARTIAL_RESET_N      <= partial_n;
         FIRST_GENERAL_PIN_O  <= int_reset_n;
         FIRST_GENERAL_PIN_OE <= gpio_oe_nxt;
         IO_GATING_SIGNAL     <= shutdown_s;
      end
   end

   // Level output always matches its code
   level_map_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      CONVERTER_LEVEL_SEL != 3'h0 |->
      CONVERTER_LEVEL_MV == 11'(11'h44C + 11'h064 * 11'(CONVERTER_LEVEL_SEL)))
      else $error("level millivolts wrong");

   // Receive with policy set forces 1.4 V
   rx_force_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (rx_level_policy && RX_ACTIVE) |=> CONVERTER_LEVEL_MV == 11'h578)
      else $error("receive level not forced");

   // Policy clear keeps the programmed level in receive
   rx_prog_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (NRST && (!rx_level_policy || !RX_ACTIVE))
      |=> CONVERTER_LEVEL_SEL == $past(converter_level_sel))
      else $error("programmed level not applied");

   // Doubled crystal halves the tick rate
   dig_rate_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (xo_double_s && DIG_CLK_EN) ##1 xo_double_s |-> !DIG_CLK_EN)
      else $error("digital tick too fast");

   // Rate word moves only on its own writes
   cfg_hold_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (int_reset_n && !(CFG_WE && CFG_IDX[1])) |=> $stable(switching_rate_word))
      else $error("rate word changed without write");

   // Bypass output follows its field one cycle later
   bypass_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      ##1 REGULATOR_BYPASS_SEL == $past(regulator_bypass_sel))
      else $error("bypass mode not applied");

   // Full reset restores defaults
   cfg_default_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      !int_reset_n |=> POWER_CFG_LEVEL == CFG_LEVEL_RST && POWER_CFG_RATE_HIGH == 8'h00)
      else $error("defaults not restored");

   // Pin mirrors the internal reset
   gpio_mirror_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      FIRST_GENERAL_PIN_O == INTERNAL_RESET_N)
      else $error("pin does not show reset");

   // Soft command: internal partial pulse first, then the registered output
   sequence partial_int_s;
      !partial_n && int_reset_n;
   endsequence
   sequence partial_pin_s;
      !PARTIAL_RESET_N;
   endsequence

   // Soft command: partial pulse without full reset
   partial_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (SOFT_PARTIAL_RESET_CMD && int_reset_n && supply_ok_s && !shutdown_s)
      |=> partial_int_s ##1 partial_pin_s)
      else $error("partial reset wrong");

   // Shutdown gates the I/O
   gating_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      shutdown_s |=> IO_GATING_SIGNAL && !FIRST_GENERAL_PIN_OE)
      else $error("I/O not gated in shutdown");

   // Reset output changes only on a clock edge after the sequencer
   sync_rel_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      $rose(INTERNAL_RESET_N) |-> $past(int_reset_n) && !$past(INTERNAL_RESET_N))
      else $error("reset release not synchronous");

   // Plain crystal ticks every cycle; NRST term skips the release edge
   dig_every_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (NRST && !xo_double_s) |=> DIG_CLK_EN)
      else $error("digital tick missing");

   // Code zero drives no level
   level_zero_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      CONVERTER_LEVEL_SEL == 3'h0 |-> CONVERTER_LEVEL_MV == 11'h000)
      else $error("level shown for code zero");

   // Shutdown release enables the I/O again
   gating_off_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (NRST && !shutdown_s) |=> !IO_GATING_SIGNAL && FIRST_GENERAL_PIN_OE)
      else $error("I/O still gated after shutdown");
endmodule
`default_nettype wire

// ==== verification/pmr_host_model.sv ====
// Host controller model: turns bench requests into config writes and
// timed shutdown pulses. Assumes requests change just after a SYS_CLK edge.
`default_nettype none
module pmr_host_model (
   input  wire logic       clk,
   input  wire logic       keep_rules,
   input  wire logic       req,
   input  wire logic [1:0] req_idx,
   input  wire logic [7:0] req_data,
   input  wire logic       sdn_req,
   output logic            cfg_we,
   output logic [1:0]      cfg_idx,
   output logic [7:0]      cfg_wdata,
   output logic            shutdown
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD_CYC = 250; // 1 us at 4 ns
   logic       bypass_r;
   logic [7:0] lvl;
   int         hold_cnt;

   // Idle bus values change every cycle after the last write so stale data never stays on the bus
   initial begin
      cfg_we = 1'b0;
      cfg_idx = 2'h0;
      cfg_wdata = 8'hA5;
      bypass_r = 1'b0;
      hold_cnt = 0;
   end

   // Level actually sent when the host obeys its supply limits
   always_comb begin
      lvl = req_data;
      if (keep_rules && req_idx == 2'h0) begin
         if (bypass_r) lvl = 8'h01;
         else if (req_data[2:0] < 3'h3) lvl = {req_data[7:3], 3'h3};
      end
   end

   // Writes go out one edge after request, whether or not the device is out of reset
   always @(posedge clk) begin
      cfg_we <= req;
      cfg_idx <= req ? req_idx : cfg_idx + 2'h1;
      cfg_wdata <= req ? lvl : ~cfg_wdata;
      if (req && req_idx == 2'h1) bypass_r <= req_data[1];
      if (sdn_req) hold_cnt <= HOLD_CYC;
      else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
   end
   assign shutdown = (hold_cnt > 0);
endmodule
`default_nettype wire

// ==== verification/pmr_power_reset_ctrl_tb.sv ====
// Self-checking bench for the power and reset controller against a
// behavioural model. Assumes the host model file is compiled first.
`default_nettype none
module pmr_power_reset_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RC = 20; // Short reset pulse for simulation
   logic sys_clk, nrst, supply_ok, xo_double, soft_cmd, rx_active;
   logic keep_rules, req, sdn_req;
   logic [1:0]  req_idx;
   logic [7:0]  req_data;
   wire logic   cfg_we, shutdown;
   wire logic [1:0] cfg_idx;
   wire logic [7:0] cfg_wdata;
   logic [7:0]  lvl_o, mode_o, lo_o, hi_o;
   logic [2:0]  sel_o;
   logic [10:0] mv_o;
   logic        byp_o, dig_en, sw_clk, rst_n, part_n, pin_o, pin_oe, gate_o;
   logic [31:0] seed = 32'h0000C60B;
   int          m_cfg[4];
   int          num_errors = 0;
   int          n_tests = 0;

   pmr_power_reset_ctrl #(.RESET_CYCLES(RC)) pmr_power_reset_ctrl_i (
      .SYS_CLK(sys_clk), .NRST(nrst), .SUPPLY_OK(supply_ok),
      .SHUTDOWN_INPUT(shutdown), .XO_DOUBLE(xo_double),
      .SOFT_PARTIAL_RESET_CMD(soft_cmd), .RX_ACTIVE(rx_active), .CFG_WE(cfg_we),
      .CFG_IDX(cfg_idx), .CFG_WDATA(cfg_wdata), .POWER_CFG_LEVEL(lvl_o),
      .POWER_CFG_MODE(mode_o), .POWER_CFG_RATE_LOW(lo_o), .POWER_CFG_RATE_HIGH(hi_o),
      .CONVERTER_LEVEL_SEL(sel_o), .CONVERTER_LEVEL_MV(mv_o),
      .REGULATOR_BYPASS_SEL(byp_o), .DIG_CLK_EN(dig_en), .SWITCH_CLK(sw_clk),
      .INTERNAL_RESET_N(rst_n), .PARTIAL_RESET_N(part_n), .FIRST_GENERAL_PIN_O(pin_o),
      .FIRST_GENERAL_PIN_OE(pin_oe), .IO_GATING_SIGNAL(gate_o));

   pmr_host_model pmr_host_model_i (
      .clk(sys_clk), .keep_rules(keep_rules), .req(req), .req_idx(req_idx),
      .req_data(req_data), .sdn_req(sdn_req), .cfg_we(cfg_we), .cfg_idx(cfg_idx),
      .cfg_wdata(cfg_wdata), .shutdown(shutdown));

   // Free-running system clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic report_and_stop();
      if (num_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input int exp);
      n_tests++;
      if (seen !== 16'(exp)) begin
         num_errors++;
         $display("mismatch at %0t: got %0h want %0h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction

   task automatic wr(input logic [1:0] i, input logic [7:0] d);
      @(posedge sys_clk);
      req <= 1'b1;
      req_idx <= i;
      req_data <= d;
      @(posedge sys_clk);
      req <= 1'b0;
      m_cfg[i] = d;
   endtask

   // Readbacks and derived outputs against the model, writes having settled
   task automatic cmp_all();
      int code;
      tick(3);
      code = (m_cfg[1][0] && rx_active) ? 3 : m_cfg[0] % 8;
      check(lvl_o, m_cfg[0]);
      check(mode_o, m_cfg[1]);
      check(lo_o, m_cfg[2]);
      check(hi_o, m_cfg[3]);
      check(sel_o, code);
      check(mv_o, code == 0 ? 0 : 1100 + 100 * code);
      check(byp_o, m_cfg[1] / 2 % 2);
   endtask

   task automatic wait_up(input int lim, output int n);
      n = 0;
      while (rst_n !== 1'b1 && n < lim) begin
         tick(1);
         n++;
      end
   endtask

   task automatic count_sw(input int n, output int rises, output int ticks);
      logic prev;
      rises = 0;
      ticks = 0;
      prev = sw_clk;
      repeat (n) begin
         tick(1);
         if (sw_clk === 1'b1 && prev === 1'b0) rises++;
         if (dig_en === 1'b1) ticks++;
         prev = sw_clk;
      end
   endtask

   // Hang guard, far beyond the expected run length
   initial begin
      #(40000 * 4);
      num_errors++;
      report_and_stop();
   end

   initial begin
      int n, r, t, w, code;
      nrst = 1'b0; supply_ok = 1'b1; xo_double = 1'b0; soft_cmd = 1'b0;
      rx_active = 1'b0; keep_rules = 1'b0; req = 1'b0; sdn_req = 1'b0;
      req_idx = 2'h0; req_data = 8'h00;
      m_cfg = '{4, 0, 0, 0};
      tick(2);
      check(lvl_o, 8'h04);
      check(rst_n, 0);
      check(pin_o, 0);
      @(posedge sys_clk) nrst <= 1'b1;
      wait_up(200, n);
      check(pin_o, 1);
      check(pin_oe, 1);
      cmp_all();
      // Every level code under both policies, receive on only when code bits 0 and 2 differ
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         wr(2'h1, {seed[7:2], 1'b0, 1'(i / 8)});
         wr(2'h0, {seed[15:11], 3'(i)});
         @(posedge sys_clk) rx_active <= 1'((i >> 2) ^ i);
         cmp_all();
      end
      // Host that honours its supply limits
      keep_rules = 1'b1;
      wr(2'h1, 8'h02);
      wr(2'h0, 8'h05);
      m_cfg[0] = 1;
      cmp_all();
      wr(2'h1, 8'h00);
      wr(2'h0, 8'h01);
      m_cfg[0] = 3;
      cmp_all();
      keep_rules = 1'b0;
      // Fixed divider at both crystal ranges
      count_sw(256, r, t);
      check(t, 256);
      check(r >= 63 && r <= 64, 1);
      @(posedge sys_clk) xo_double <= 1'b1;
      tick(8);
      count_sw(256, r, t);
      check(t, 128);
      check(r >= 31 && r <= 32, 1);
      @(posedge sys_clk) xo_double <= 1'b0;
      // Fractional word: documented example, then a random one
      seed = xs(seed);
      for (int k = 0; k < 2; k++) begin
         w = (k == 0) ? 32'h07FC : 1024 + seed % 15360;
         wr(2'h2, w[7:0]);
         wr(2'h3, 8'h80 | w[14:8]);
         cmp_all();
         count_sw(4096, r, t);
         check(r * 8 - w <= 8 && w - r * 8 <= 8, 1);
      end
      // Soft command: one-cycle partial reset, config kept
      @(posedge sys_clk) soft_cmd <= 1'b1;
      @(posedge sys_clk) soft_cmd <= 1'b0;
      #1;
      check(part_n, 1);
      tick(1);
      check(part_n, 0);
      tick(1);
      check(part_n, 1);
      check(rst_n, 1);
      cmp_all();
      // Supply loss drops the reset quickly
      @(posedge sys_clk) supply_ok <= 1'b0;
      tick(6);
      check(rst_n, 0);
      @(posedge sys_clk) supply_ok <= 1'b1;
      wait_up(200, n);
      m_cfg = '{4, 0, 0, 0};
      cmp_all();
      // Fresh level first so the shutdown reset has something to restore;
      // a write inside the pulse must be dropped
      wr(2'h0, 8'h06);
      @(posedge sys_clk) sdn_req <= 1'b1;
      @(posedge sys_clk) sdn_req <= 1'b0;
      tick(10);
      check(gate_o, 1);
      check(pin_oe, 0);
      check(rst_n, 0);
      wr(2'h0, 8'h07);
      m_cfg = '{4, 0, 0, 0};
      n = 0;
      while (shutdown === 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      wait_up(200, n);
      check(n >= RC + 2 && n <= RC + 8, 1);
      check(gate_o, 0);
      check(pin_o, 1);
      cmp_all();
      report_and_stop();
   end
endmodule
`default_nettype wire
